// ### logic/erbc_core.sv
// The implementer's own choices: the placing of the registers and the plain strobed port.
`timescale 1ns/10ps
module erbc_core import erbc_pkg::*; #(
  parameter erbc_cyc_arr_t CR_CYC = CR_CYC_DEF,
  parameter int unsigned RST_CYC = RST_CYC_DEF,
  parameter int RT_W = 40,
  parameter int IV_W = 32
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata_q,
  input wire logic fetch_valid,
  input wire logic [31:0] fetch_addr,
  input wire logic [3:0] hw_match_unit,
  input wire logic sw_bp_hit,
  input wire logic bp_seq_hit,
  input wire logic [2:0] gen_brk_hit,
  input wire logic perf_timeout,
  input wire logic perf_count_ovf,
  output logic target_reset_input_q,
  output logic tgt_halt_q,
  output logic tgt_load_q,
  output logic [31:0] tgt_pc_q,
  output logic trace_en_q
);
  erbc_state_t st_q, st_d;
  logic [MODE_W-1:0] mode_q;
  logic [CRSEL_W-1:0] crsel_q, cr_idx;
  logic [SSEL_W-1:0] ssel_q;
  logic brk_en_q;
  logic [1:0] res_q;
  logic [31:0] start_q, brkad_q, rst_cnt_q;
  logic [CAUSE_W-1:0] cause_q, cause_d;
  logic [1:0] seq_q, seq_last;
  logic [RT_W-1:0] rt_q;
  logic rt_ovf_q, rt_tick, cr_tick, halt_d;
  logic wr_ctrl, go, abort_w, st_run, addr_hit, seq_hit;
  logic m_norm, m_cr, m_nb, m_iv, m_sb, m_tb, gen_ok;
  logic [3:0] um;
  logic iva_busy, ivb_busy;
  logic [IV_W-1:0] iva_tot, iva_max, iva_min, iva_cnt;
  logic [IV_W-1:0] ivb_tot, ivb_max, ivb_min, ivb_cnt;

  assign wr_ctrl = reg_wr && reg_addr == A_CTRL;
  assign go = wr_ctrl && reg_wdata[F_GO] && st_q == ST_IDLE;
  assign abort_w = wr_ctrl && reg_wdata[F_ABORT] && st_q != ST_IDLE;
  assign st_run = st_q == ST_RUN;

  assign m_cr = mode_q == M_CR;
  assign m_nb = mode_q == M_NB;
  assign m_iv = mode_q inside {M_I1, M_I2, M_I3};
  assign m_sb = mode_q inside {M_SB1, M_SB2, M_SB3};
  assign m_tb = mode_q == M_TB;
  // Unknown mode codes fall back to normal emulation
  assign m_norm = !(m_cr || m_nb || m_iv || m_sb || m_tb);
  assign gen_ok = !(m_cr || m_nb || m_iv);

  // Unit 4 is spent on the break address while one is armed
  assign um = hw_match_unit & {~brk_en_q, 3'h7};
  // Fetch address is the next instruction; halting now stops it executing
  assign addr_hit = st_run && brk_en_q && !m_cr && fetch_valid && fetch_addr == brkad_q;

  // Configuration registers; control word fields latch only while idle, CFG, START and BRKAD at any time
  always_ff @(posedge clk) begin
    if (!resetn) begin
      mode_q <= M_NORM;
      crsel_q <= 4'h1;
      ssel_q <= S_CURPC;
      brk_en_q <= 1'b0;
    end else if (wr_ctrl && st_q == ST_IDLE) begin
      mode_q <= reg_wdata[F_MODE +: MODE_W];
      crsel_q <= reg_wdata[F_CRSEL +: CRSEL_W];
      ssel_q <= reg_wdata[F_SSEL +: SSEL_W];
      brk_en_q <= reg_wdata[F_BRK];
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      res_q <= 2'h0;
      start_q <= '0;
      brkad_q <= '0;
    end else if (reg_wr) begin
      if (reg_addr == A_CFG && reg_wdata[1:0] <= RES_LAST)
        res_q <= reg_wdata[1:0];
      if (reg_addr == A_START)
        start_q <= reg_wdata;
      if (reg_addr == A_BRKAD)
        brkad_q <= reg_wdata;
    end
  end

  // Out-of-range selectors clamp to the nearest table entry
  always_comb begin
    cr_idx = crsel_q - 4'h1;
    if (crsel_q == 4'h0)
      cr_idx = 4'h0;
    if (crsel_q > CR_SEL_MAX)
      cr_idx = CR_SEL_MAX - 4'h1;
  end

  erbc_tick #(.W(32)) u_rt_tick (
    .clk(clk),
    .resetn(resetn),
    .en(st_q != ST_IDLE),
    .period(RES_CYC[res_q]),
    .tick_q(rt_tick)
  );

  erbc_tick #(.W(32)) u_cr_tick (
    .clk(clk),
    .resetn(resetn),
    .en(st_run && m_cr),
    // Net of the pulse and the state hop, so reset rises stay one interval apart
    .period(CR_CYC[cr_idx] - RST_CYC - 32'h1),
    .tick_q(cr_tick)
  );

  // Sequence tracker: expects units last..0 in descending order
  always_comb begin
    seq_last = 2'h1;
    if (mode_q == M_SB2)
      seq_last = 2'h2;
    if (mode_q == M_SB3)
      seq_last = 2'h3;
  end
  assign seq_hit = um[seq_last - seq_q];

  always_ff @(posedge clk) begin
    if (!resetn || go)
      seq_q <= 2'h0;
    else if (st_run && m_sb && seq_hit && seq_q != seq_last)
      seq_q <= seq_q + 2'h1;
  end

  erbc_ivl #(.W(IV_W)) u_iva (
    .clk(clk),
    .resetn(resetn),
    .clr(go),
    .tick(rt_tick),
    .start(st_run && m_iv && um[1]),
    .stop(um[0]),
    .busy_q(iva_busy),
    .total_q(iva_tot),
    .max_q(iva_max),
    .min_q(iva_min),
    .cnt_q(iva_cnt)
  );

  erbc_ivl #(.W(IV_W)) u_ivb (
    .clk(clk),
    .resetn(resetn),
    .clr(go),
    .tick(rt_tick),
    .start(st_run && mode_q == M_I3 && um[3]),
    .stop(um[2]),
    .busy_q(ivb_busy),
    .total_q(ivb_tot),
    .max_q(ivb_max),
    .min_q(ivb_min),
    .cnt_q(ivb_cnt)
  );

  // Break arbitration; abort beats the stop address beats the rest
  always_comb begin
    halt_d = 1'b1;
    cause_d = C_NONE;
    if (abort_w)
      cause_d = C_ABORT;
    else if (!st_run)
      halt_d = 1'b0;
    else if (addr_hit)
      cause_d = C_STOP;
    else if (m_norm && sw_bp_hit)
      cause_d = C_SWBP;
    else if (m_norm && bp_seq_hit)
      cause_d = C_BPSEQ;
    else if (gen_ok && |gen_brk_hit)
      cause_d = C_GEN;
    else if (m_norm && |um)
      cause_d = C_UBC;
    else if (mode_q == M_I1 && iva_busy && um[0])
      cause_d = C_SB;
    else if (m_sb && seq_hit && seq_q == seq_last)
      cause_d = C_SB;
    else if (m_tb && perf_timeout)
      cause_d = C_TMO;
    else if (m_tb && perf_count_ovf)
      cause_d = C_CNT;
    else
      halt_d = 1'b0;
  end

  always_comb begin
    st_d = st_q;
    unique case (st_q)
      ST_IDLE:
        if (go)
          st_d = ssel_q == S_RESET ? ST_RST : ST_RUN;
      ST_RST:
        if (abort_w)
          st_d = ST_IDLE;
        else if (rst_cnt_q >= RST_CYC - 1)
          st_d = ST_RUN;
      ST_RUN:
        if (halt_d)
          st_d = ST_IDLE;
        else if (m_cr && cr_tick)
          st_d = ST_RST;
      default:
        st_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!resetn)
      st_q <= ST_IDLE;
    else
      st_q <= st_d;
  end

  always_ff @(posedge clk) begin
    if (!resetn || st_q != ST_RST)
      rst_cnt_q <= '0;
    else
      rst_cnt_q <= rst_cnt_q + 32'h1;
  end

  // Target side outputs
  always_ff @(posedge clk) begin
    if (!resetn) begin
      target_reset_input_q <= 1'b0;
      trace_en_q <= 1'b0;
    end else begin
      target_reset_input_q <= st_d == ST_RST;
      trace_en_q <= st_d != ST_IDLE && !m_cr && !m_iv;
    end
  end

  // Target comes out of reset halted until the first run
  always_ff @(posedge clk) begin
    if (!resetn) begin
      tgt_halt_q <= 1'b1;
      cause_q <= C_NONE;
    end else if (go) begin
      tgt_halt_q <= 1'b0;
      cause_q <= C_NONE;
    end else if (halt_d) begin
      tgt_halt_q <= 1'b1;
      cause_q <= cause_d;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      tgt_load_q <= 1'b0;
      tgt_pc_q <= '0;
    end else begin
      tgt_load_q <= go && ssel_q == S_ADDR;
      if (go && ssel_q == S_ADDR)
        tgt_pc_q <= start_q;
    end
  end

  // Run timer; span is about 2^RT_W ticks for every resolution
  always_ff @(posedge clk) begin
    if (!resetn || go) begin
      rt_q <= '0;
      rt_ovf_q <= 1'b0;
    end else if (rt_tick) begin
      rt_q <= rt_q + RT_W'(1);
      if (&rt_q)
        rt_ovf_q <= 1'b1;
    end
  end

  // Register read port, data one cycle after the strobe
  always_ff @(posedge clk) begin
    if (!resetn)
      reg_rdata_q <= '0;
    else if (reg_rd) begin
      reg_rdata_q <= '0;
      unique case (reg_addr)
        A_CTRL:
          reg_rdata_q <= 32'({crsel_q, mode_q, brk_en_q, ssel_q, 2'h0});
        A_CFG:
          reg_rdata_q <= 32'(res_q);
        A_START:
          reg_rdata_q <= start_q;
        A_BRKAD:
          reg_rdata_q <= brkad_q;
        A_STATUS:
          reg_rdata_q <= 32'({seq_q, cause_q, ivb_busy, iva_busy, rt_ovf_q, tgt_halt_q, st_q != ST_IDLE});
        A_RT_LO:
          reg_rdata_q <= rt_q[31:0];
        A_RT_HI:
          reg_rdata_q <= 32'(rt_q >> 32);
        A_IVA + IV_TOT:
          reg_rdata_q <= 32'(iva_tot);
        A_IVA + IV_MAX:
          reg_rdata_q <= 32'(iva_max);
        A_IVA + IV_MIN:
          reg_rdata_q <= 32'(iva_min);
        A_IVA + IV_CNT:
          reg_rdata_q <= 32'(iva_cnt);
        A_IVB + IV_TOT:
          reg_rdata_q <= 32'(ivb_tot);
        A_IVB + IV_MAX:
          reg_rdata_q <= 32'(ivb_max);
        A_IVB + IV_MIN:
          reg_rdata_q <= 32'(ivb_min);
        A_IVB + IV_CNT:
          reg_rdata_q <= 32'(ivb_cnt);
        default:
          reg_rdata_q <= '0;
      endcase
    end
  end

  // Checks
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);

  logic quiet;
  assign quiet = !abort_w && !addr_hit;

  a_stop_addr_halt: assert property (!abort_w && addr_hit |=> tgt_halt_q && cause_q == C_STOP)
    else $error("break address did not halt");
  a_unit4_masked: assert property (st_run && brk_en_q && m_norm && quiet && hw_match_unit == 4'h8
    && !sw_bp_hit && !bp_seq_hit && gen_brk_hit == 3'h0 |=> !tgt_halt_q)
    else $error("unit 4 break while address armed");
  a_reset_start: assert property (go && ssel_q == S_RESET |=> target_reset_input_q && !tgt_load_q)
    else $error("run from reset gave no target reset");
  a_resume_addr: assert property (go && ssel_q == S_ADDR |=> tgt_load_q && tgt_pc_q == $past(start_q))
    else $error("start address not loaded");
  a_resume_curpc: assert property (go && ssel_q == S_CURPC |=> !tgt_load_q && !target_reset_input_q)
    else $error("current pc run disturbed target");
  a_norm_swbp: assert property (st_run && m_norm && quiet && sw_bp_hit |=> tgt_halt_q && cause_q == C_SWBP)
    else $error("software breakpoint missed");
  a_cr_period: assert property (st_run && m_cr && cr_tick && !abort_w |=> target_reset_input_q [*2])
    else $error("cycle reset pulse missing");
  a_cr_nobreak: assert property (st_q != ST_IDLE && m_cr && !abort_w |=> !tgt_halt_q && !trace_en_q)
    else $error("break or trace in cycle reset");
  a_nb_ignore: assert property (st_run && m_nb && quiet |=> !tgt_halt_q)
    else $error("break in suppress mode");
  a_i1_halt: assert property (st_run && mode_q == M_I1 && iva_busy && um[0] && quiet
    && gen_brk_hit == 3'h0 |=> tgt_halt_q && cause_q == C_SB)
    else $error("interval mode one did not halt");
  a_iv_nohalt: assert property (st_run && (mode_q == M_I2 || mode_q == M_I3) && quiet |=> !tgt_halt_q)
    else $error("interval mode halted");
  a_sb3_order: assert property ($rose(tgt_halt_q) && cause_q == C_SB && mode_q == M_SB3
    |-> $past(seq_q) == 2'h3)
    else $error("sequence halt out of order");
  a_tb_timeout: assert property (st_run && m_tb && quiet && gen_brk_hit == 3'h0 && perf_timeout
    |=> tgt_halt_q && cause_q == C_TMO)
    else $error("timeout break missed");
  a_rt_overflow: assert property (rt_tick && &rt_q && !go |=> rt_ovf_q)
    else $error("run timer overflow not flagged");
  a_ivl_count: assert property (iva_busy && um[0] && !go |=> iva_cnt == $past(iva_cnt) + IV_W'(1))
    else $error("interval count not advanced");

  c_reset_run: cover property (go && ssel_q == S_RESET ##[1:40] st_run);
  c_cr_cycle: cover property (st_run && m_cr && cr_tick);
  c_sb3_halt: cover property ($rose(tgt_halt_q) && cause_q == C_SB && mode_q == M_SB3);
  c_i2_sample: cover property (mode_q == M_I2 && iva_busy && um[0]);
endmodule // erbc_core

// ### logic/erbc_ivl.sv
`timescale 1ns/10ps
module erbc_ivl #(
  parameter int W = 32
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic clr,
  input wire logic tick,
  input wire logic start,
  input wire logic stop,
  output logic busy_q,
  output logic [W-1:0] total_q,
  output logic [W-1:0] max_q,
  output logic [W-1:0] min_q,
  output logic [W-1:0] cnt_q
);
  logic [W-1:0] cur_q;

  // A second start while open keeps the first
  always_ff @(posedge clk) begin
    if (!resetn || clr)
      busy_q <= 1'b0;
    else if (busy_q && stop)
      busy_q <= 1'b0;
    else if (start)
      busy_q <= 1'b1;
  end

  always_ff @(posedge clk) begin
    if (!resetn || clr || !busy_q)
      cur_q <= '0;
    else if (tick)
      cur_q <= cur_q + W'(1);
  end

  always_ff @(posedge clk) begin
    if (!resetn || clr) begin
      total_q <= '0;
      max_q <= '0;
      min_q <= '1;
      cnt_q <= '0;
    end else if (busy_q && stop) begin
      total_q <= total_q + cur_q;
      cnt_q <= cnt_q + W'(1);
      if (cur_q > max_q)
        max_q <= cur_q;
      if (cur_q < min_q)
        min_q <= cur_q;
    end
  end
endmodule // erbc_ivl

// ### logic/erbc_pkg.sv
package erbc_pkg;
  localparam int CLK_PS = 5000;
  localparam int CR_N = 12;
  localparam logic [3:0] CR_SEL_MAX = 4'hc;
  typedef int unsigned erbc_cyc_arr_t [CR_N];
  localparam longint CR_NS [CR_N] = '{6500, 9800, 50000, 100000, 500000, 1000000, 5000000, 10000000,
    50000000, 100000000, 500000000, 1000000000};
  function automatic erbc_cyc_arr_t erbc_cr_cyc();
    erbc_cyc_arr_t r;
    for (int i = 0; i < CR_N; i++)
      r[i] = 32'((CR_NS[i] * 1000) / CLK_PS);
    return r;
  endfunction
  localparam erbc_cyc_arr_t CR_CYC_DEF = erbc_cr_cyc();
  localparam int RST_PULSE_NS = 100;
  localparam int unsigned RST_CYC_DEF = (RST_PULSE_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int RES_PS [3] = '{1600000, 406000, 20000};
  localparam int unsigned RES_CYC [3] = '{RES_PS[0] / CLK_PS, RES_PS[1] / CLK_PS, RES_PS[2] / CLK_PS};
  localparam logic [1:0] RES_LAST = 2'h2;
  // Register byte offsets
  localparam logic [7:0] A_CTRL = 8'h00, A_CFG = 8'h04, A_START = 8'h08, A_BRKAD = 8'h0c;
  localparam logic [7:0] A_STATUS = 8'h10, A_RT_LO = 8'h14, A_RT_HI = 8'h18;
  localparam logic [7:0] A_IVA = 8'h20, A_IVB = 8'h30;
  localparam logic [3:0] IV_TOT = 4'h0, IV_MAX = 4'h4, IV_MIN = 4'h8, IV_CNT = 4'hc;
  // Control word fields
  localparam int F_GO = 0, F_ABORT = 1, F_SSEL = 2, F_BRK = 4, F_MODE = 5, F_CRSEL = 9;
  localparam int SSEL_W = 2, MODE_W = 4, CRSEL_W = 4, CAUSE_W = 4;
  localparam logic [1:0] S_CURPC = 2'h0, S_ADDR = 2'h1, S_RESET = 2'h2;
  localparam logic [3:0] M_NORM = 4'h0, M_CR = 4'h1, M_NB = 4'h2, M_I1 = 4'h3, M_I2 = 4'h4;
  localparam logic [3:0] M_I3 = 4'h5, M_SB1 = 4'h6, M_SB2 = 4'h7, M_SB3 = 4'h8, M_TB = 4'h9;
  localparam logic [3:0] C_NONE = 4'h0, C_STOP = 4'h1, C_SWBP = 4'h2, C_BPSEQ = 4'h3, C_GEN = 4'h4;
  localparam logic [3:0] C_UBC = 4'h5, C_SB = 4'h6, C_TMO = 4'h7, C_CNT = 4'h8, C_ABORT = 4'h9;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RST = 3'b010,
    ST_RUN = 3'b100
  } erbc_state_t;
endpackage

// ### logic/erbc_tick.sv
`timescale 1ns/10ps
module erbc_tick #(
  parameter int W = 32
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic en,
  input wire logic [W-1:0] period,
  output logic tick_q
);
  logic [W-1:0] cnt_q;

  // Period of zero behaves as one
  always_ff @(posedge clk) begin
    if (!resetn || !en) begin
      cnt_q <= '0;
      tick_q <= 1'b0;
    end else if (cnt_q + W'(1) >= period) begin
      cnt_q <= '0;
      tick_q <= 1'b1;
    end else begin
      cnt_q <= cnt_q + W'(1);
      tick_q <= 1'b0;
    end
  end
endmodule // erbc_tick

// ### verif/erbc_tgt_model.sv
`timescale 1ns/10ps
module erbc_tgt_model #(
  parameter logic [31:0] RST_VEC = 32'h0000_0400
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic rst_in,
  input wire logic halt,
  input wire logic load,
  input wire logic [31:0] load_pc,
  output logic fetch_valid,
  output logic [31:0] fetch_addr,
  output logic [31:0] pc_q
);
  logic ph_q;
  // Each fetch stands two cycles, so a stop request lands before it executes
  always_ff @(posedge clk) begin
    if (!resetn) begin
      pc_q <= 32'h0;
      ph_q <= 1'b0;
    end else if (rst_in) begin
      pc_q <= RST_VEC;
      ph_q <= 1'b0;
    end else if (load) begin
      pc_q <= load_pc;
      ph_q <= 1'b0;
    end else if (!halt) begin
      ph_q <= !ph_q;
      if (ph_q) begin
        pc_q <= pc_q + 32'h2;
      end
    end
  end
  assign fetch_valid = resetn && !rst_in && !halt;
  // Released bus shows the inverse, so a stale address never matches
  assign fetch_addr = fetch_valid ? pc_q : ~pc_q;
endmodule // erbc_tgt_model

// ### verif/testbench.sv
`timescale 1ns/10ps
module testbench import erbc_pkg::*;;
  localparam erbc_cyc_arr_t CRV = '{20, 24, 28, 32, 36, 40, 44, 48, 52, 56, 60, 64};
  localparam int unsigned RSTW = 2;
  localparam logic [31:0] RVEC = 32'h0000_0400;
  logic clk, resetn, reg_wr, reg_rd, fetch_valid, sw_bp_hit, bp_seq_hit, perf_timeout, perf_count_ovf;
  logic target_reset_input_q, tgt_halt_q, tgt_load_q, trace_en_q;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata_q, fetch_addr, tgt_pc_q, mpc, d;
  logic [3:0] hw_match_unit;
  logic [2:0] gen_brk_hit;
  int n_mismatch = 0;
  int n_compared = 0;

  erbc_core #(.CR_CYC(CRV), .RST_CYC(RSTW)) dut (.clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata_q, .fetch_valid, .fetch_addr, .hw_match_unit, .sw_bp_hit, .bp_seq_hit, .gen_brk_hit,
    .perf_timeout, .perf_count_ovf, .target_reset_input_q, .tgt_halt_q, .tgt_load_q, .tgt_pc_q, .trace_en_q);
  erbc_tgt_model #(.RST_VEC(RVEC)) tgt (.clk, .resetn, .rst_in(target_reset_input_q), .halt(tgt_halt_q),
    .load(tgt_load_q), .load_pc(tgt_pc_q), .fetch_valid, .fetch_addr, .pc_q(mpc));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic rng(input logic [31:0] v, input logic [31:0] lo, input logic [31:0] hi);
    chk({31'h0, v >= lo && v <= hi}, 32'h1);
  endtask

  task automatic tmo(input int c);
    if (c >= 300) begin
      n_mismatch++;
      $display("BAD t=%0t wait ran out", $time);
      finish_test();
    end
  endtask

  // A gap cycle after each strobe keeps every signal to one assignment per step
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    d = reg_rdata_q;
    @(posedge clk);
  endtask

  task automatic cause(input logic [3:0] c);
    rd(A_STATUS);
    chk({28'h0, d[8:5]}, {28'h0, c});
  endtask

  // Bits: 3:0 units, 4 sw bp, 5 bp seq, 6 general, 7 timeout, 8 count
  task automatic src(input logic [8:0] s);
    {perf_count_ovf, perf_timeout, gen_brk_hit, bp_seq_hit, sw_bp_hit, hw_match_unit} <= {s[8:7], {3{s[6]}}, s[5:0]};
    @(posedge clk);
    {perf_count_ovf, perf_timeout, gen_brk_hit, bp_seq_hit, sw_bp_hit, hw_match_unit} <= 11'h0;
    @(posedge clk);
  endtask

  // Setup first: the go write acts on fields already stored
  task automatic go(input logic [1:0] ss, input logic bk, input logic [3:0] m, input logic [3:0] n);
    wr(A_CTRL, {19'h0, n, m, bk, ss, 2'h0});
    wr(A_CTRL, {19'h0, n, m, bk, ss, 2'h1});
  endtask

  task automatic wait_halt(input int n);
    int c;
    c = 0;
    do begin
      @(negedge clk);
      c++;
    end while (tgt_halt_q !== 1'b1 && c < n);
    if (tgt_halt_q !== 1'b1) tmo(300);
    @(posedge clk);
  endtask

  task automatic quiet(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
    chk({31'h0, tgt_halt_q}, 32'h0);
    @(posedge clk);
  endtask

  task automatic stop(input logic [3:0] c);
    wr(A_CTRL, 32'h2);
    wait_halt(4);
    cause(c);
  endtask

  task automatic rise(output int c);
    c = 0;
    while (target_reset_input_q === 1'b1 && c < 300) begin
      @(negedge clk);
      c++;
    end
    while (target_reset_input_q !== 1'b1 && c < 300) begin
      @(negedge clk);
      c++;
    end
    tmo(c);
  endtask

  task automatic s_stop();
    wr(A_START, 32'h100);
    wr(A_BRKAD, 32'h108);
    go(S_ADDR, 1'b1, M_NORM, 4'h1);
    src(9'h008);
    wait_halt(40);
    chk(mpc, 32'h108);
    cause(C_STOP);
  endtask

  task automatic s_norm();
    logic [8:0] s [4] = '{9'h010, 9'h020, 9'h040, 9'h001};
    logic [3:0] c [4] = '{C_SWBP, C_BPSEQ, C_GEN, C_UBC};
    for (int i = 0; i < 4; i++) begin
      go(S_CURPC, 1'b0, M_NORM, 4'h1);
      quiet(2);
      rng(mpc, 32'h108, 32'h140);
      chk({31'h0, trace_en_q}, 32'h1);
      src(s[i]);
      wait_halt(3);
      cause(c[i]);
    end
  endtask

  task automatic s_ign();
    logic [3:0] m [5] = '{M_NB, M_CR, M_I2, M_SB1, M_TB};
    logic [8:0] s [5] = '{9'h1ff, 9'h1ff, 9'h070, 9'h031, 9'h030};
    for (int i = 0; i < 5; i++) begin
      go(S_CURPC, 1'b0, m[i], 4'h1);
      src(s[i]);
      quiet(4);
      if (i == 1 || i == 2) chk({31'h0, trace_en_q}, 32'h0);
      stop(C_ABORT);
    end
    go(S_CURPC, 1'b0, M_NORM, 4'h1);
    src(9'h010);
    wait_halt(3);
    cause(C_SWBP);
  endtask

  // Partial sequences first: they must not halt, nor spoil the later full one
  task automatic s_seq();
    for (int k = 0; k < 3; k++) begin
      go(S_CURPC, 1'b0, M_SB1 + 4'(k), 4'h1);
      for (int u = k; u >= 0; u--) src(9'(1 << u));
      for (int u = k + 1; u > 0; u--) begin
        quiet(1);
        src(9'(1 << u));
      end
      quiet(1);
      src(9'h001);
      wait_halt(2);
      cause(C_SB);
    end
  endtask

  task automatic s_tb();
    for (int j = 0; j < 2; j++) begin
      go(S_CURPC, 1'b0, M_TB, 4'h1);
      src(9'h030);
      quiet(1);
      src(j ? 9'h100 : 9'h080);
      wait_halt(2);
      cause(j ? C_CNT : C_TMO);
    end
  endtask

  task automatic s_rst();
    go(S_RESET, 1'b0, M_NORM, 4'h1);
    @(negedge clk);
    chk({31'h0, target_reset_input_q}, 32'h1);
    quiet(RSTW + 1);
    chk({31'h0, target_reset_input_q}, 32'h0);
    rng(mpc, RVEC, RVEC + 32'h8);
    stop(C_ABORT);
  endtask

  task automatic s_cr();
    int c;
    for (int n = 1; n <= 12; n++) begin
      go(S_CURPC, 1'b0, M_CR, 4'(n));
      rise(c);
      rise(c);
      chk(32'(c), CRV[n-1]);
      @(posedge clk);
      stop(C_ABORT);
    end
  endtask

  task automatic s_rt();
    int e;
    for (int r = 0; r < 3; r++) begin
      wr(A_CFG, 32'(r));
      go(S_CURPC, 1'b0, M_NORM, 4'h1);
      repeat (640) @(posedge clk);
      stop(C_ABORT);
      rd(A_RT_LO);
      e = 640 / RES_CYC[r];
      rng(d, 32'(e - 1), 32'(e + 2));
    end
  endtask

  // Ticks are 4 cycles; the tick phase leaves one tick of slack
  task automatic s_ivl();
    logic [31:0] lo [4] = '{28, 19, 9, 2};
    logic [31:0] hi [4] = '{32, 21, 11, 2};
    wr(A_CFG, 32'h2);
    go(S_CURPC, 1'b0, M_I1, 4'h1);
    src(9'h002);
    repeat (38) @(posedge clk);
    src(9'h001);
    wait_halt(2);
    cause(C_SB);
    rd(A_IVA);
    rng(d, 32'd9, 32'd11);
    go(S_CURPC, 1'b0, M_I2, 4'h1);
    for (int i = 1; i < 3; i++) begin
      src(9'h002);
      repeat (40 * i - 2) @(posedge clk);
      src(9'h001);
    end
    quiet(2);
    stop(C_ABORT);
    for (int j = 0; j < 4; j++) begin
      rd(A_IVA + 8'(4 * j));
      rng(d, lo[j], hi[j]);
    end
    go(S_CURPC, 1'b0, M_I3, 4'h1);
    src(9'h00a);
    repeat (38) @(posedge clk);
    src(9'h001);
    repeat (38) @(posedge clk);
    src(9'h004);
    quiet(2);
    stop(C_ABORT);
    rd(A_IVA);
    rng(d, 32'd9, 32'd11);
    rd(A_IVB);
    rng(d, 32'd19, 32'd21);
  endtask

  initial begin
    resetn = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h0;
    reg_wdata = 32'h0;
    {perf_count_ovf, perf_timeout, gen_brk_hit, bp_seq_hit, sw_bp_hit, hw_match_unit} = 11'h0;
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    s_stop();
    s_norm();
    s_ign();
    s_seq();
    s_tb();
    s_rst();
    s_cr();
    s_rt();
    s_ivl();
    rd(8'h40);
    chk(d, 32'h0);
    finish_test();
  end
endmodule // testbench
